// >>> rtl/vsbt_pkg.sv
// Purpose: Shared constants for the vertical sync and blank timing block
// Assumes: Avalon-MM byte addresses, 32-bit data, one register per word
// Notes: Line fields are 11 bits wide; reserved bits read as zero
package vsbt_pkg;

  // Register byte addresses
  localparam logic [15:0] OFS_CRT_VSYNC = 16'h8348;
  localparam logic [15:0] OFS_PANEL_VSYNC = 16'h834c;
  localparam logic [15:0] OFS_CONTROL = 16'h8300;
  localparam logic [15:0] OFS_GEOMETRY = 16'h8304;
  localparam logic [15:0] OFS_BLANK = 16'h8308;
  localparam logic [15:0] OFS_STATUS = 16'h830c;

  // Field layout of the two sync timing registers, the geometry register and the blank register
  localparam int LINE_W = 11;
  localparam int BEGIN_LO = 0;
  localparam int STOP_LO = 16;
  localparam logic [31:0] SYNC_REG_MASK = 32'h07ff07ff;
  localparam logic [31:0] BLANK_REG_MASK = 32'h000007ff;

  // Control register bits
  localparam int CTL_INTERLACE_BIT = 0;
  localparam int CTL_LOCK_BIT = 1;

  // Status register bits
  localparam int STS_FIELD_BIT = 16;
  localparam int STS_VBLANK_BIT = 17;
  localparam int STS_VSYNC_BIT = 18;

  // Reset values
  localparam logic [31:0] SYNC_REG_RESET = 32'h00000000;
  localparam logic [10:0] LINE_RESET = 11'h000;

  // Threshold offsets, in lines
  localparam logic [10:0] CRT_OFFSET = 11'h001;
  localparam logic [10:0] PANEL_OFFSET = 11'h002;
  localparam logic [10:0] ILACE_BLANK_OFFSET = 11'h002;

endpackage

// >>> rtl/vsbt_panel_stage.sv
// Purpose: Flat-panel output stage holding the panel vertical sync
// Assumes: Same clock as the timing comparators
// Notes: Adds one clock of delay after the internal panel sync
`timescale 1ns/1ps

module vsbt_panel_stage (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic fp_vsync_int,
  output logic panel_vsync
);

  typedef struct packed {
    logic vsync;
  } vsbt_stage_t;

  vsbt_stage_t s_r;
  vsbt_stage_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Capture the internal sync before it reaches the panel pin
  always_comb begin
    s_nxt = s_r;
    s_nxt.vsync = fp_vsync_int; // [R10]
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign panel_vsync = s_r.vsync;

endmodule // vsbt_panel_stage

// >>> rtl/vsbt_timing.sv
// Purpose: Vertical blank, CRT sync and panel sync comparators with registers
// Assumes: Line events come from horizontal timing, synchronous to core_clk
// Notes: Thresholds are compared against the scan line counter only
// Operation
// R1: Blank asserts at line equal to blank-start field plus one.
// R2: Software programs blank start as visible count plus one when interlaced.
// R3: Interlaced mode has no border; blank follows total and visible counts.
// R4: CRT vertical sync ends at line equal to sync-stop field plus one.
// R5: CRT vertical sync begins at line equal to sync-begin field plus one.
// R6: Interlaced counter advances at mid-line and at line end.
// R7: Odd total interlaced: sync alternates mid-line and line end per field.
// R8: Internal panel sync ends at panel stop field plus two.
// R9: Internal panel sync begins at panel begin field plus two.
// R10: Panel sync is registered once before leaving for the panel.
// R11: CRT sync register is read/write; writes blocked while locked.
// R12: Panel sync register is read/write; writes blocked while locked.
// R13: All vertical thresholds compare against scan lines.
// R14: Visible count is displayed lines minus one; thresholds relate to it.
// R15: Line counter starts at zero each frame and wraps after total.
// R16: Software writes zero to reserved bits of both sync registers.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module vsbt_timing (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic line_end_pls,
  input wire logic mid_line_pls,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  output logic vblank,
  output logic crt_vsync,
  output logic panel_vsync
);

  typedef struct packed {
    logic [31:0] crt_reg;
    logic [31:0] panel_reg;
    logic interlace;
    logic lock;
    logic [10:0] total;
    logic [10:0] visible;
    logic [10:0] blank_start;
    logic [10:0] line;
    logic field;
    logic vblank;
    logic vsync;
    logic fp_int;
    logic wreq;
    logic [31:0] rdata;
  } vsbt_state_t;

  vsbt_state_t s_r;
  vsbt_state_t s_nxt;

  logic adv;
  logic wr_go;
  logic [10:0] line_nxt;
  logic [10:0] blank_thr;
  logic [10:0] crt_begin;
  logic [10:0] crt_stop;
  logic [10:0] fp_begin;
  logic [10:0] fp_stop;
  logic [31:0] geo_wr;
  logic [31:0] blank_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge for the sync, geometry and blank registers
  function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Field plus a line offset, wrapping inside 11 bits
  function automatic logic [10:0] line_plus(input logic [10:0] v, input logic [10:0] k);
    return 11'(v + k);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction and thresholds
  assign crt_begin = s_r.crt_reg[vsbt_pkg::BEGIN_LO +: vsbt_pkg::LINE_W];
  assign crt_stop = s_r.crt_reg[vsbt_pkg::STOP_LO +: vsbt_pkg::LINE_W];
  assign fp_begin = s_r.panel_reg[vsbt_pkg::BEGIN_LO +: vsbt_pkg::LINE_W];
  assign fp_stop = s_r.panel_reg[vsbt_pkg::STOP_LO +: vsbt_pkg::LINE_W];
  // Merged write images, since a call result cannot be part-selected
  assign geo_wr = merge32({5'h00, s_r.total, 5'h00, s_r.visible}, avs_writedata,
                          avs_byteenable);
  assign blank_wr = merge32({21'h000000, s_r.blank_start}, avs_writedata,
                            avs_byteenable);
  // No border when interlaced, so blank is derived from the visible count
  assign blank_thr = s_r.interlace ?
                     line_plus(s_r.visible, vsbt_pkg::ILACE_BLANK_OFFSET) : // [R3] [R14]
                     line_plus(s_r.blank_start, vsbt_pkg::CRT_OFFSET); // [R1]

  // Counter steps on line ends, plus mid-lines when interlaced
  assign adv = line_end_pls | (s_r.interlace & mid_line_pls); // [R6] [R13]
  // Wrap after the programmed total
  assign line_nxt = (s_r.line == s_r.total) ? vsbt_pkg::LINE_RESET :
                    line_plus(s_r.line, 11'h001); // [R15]
  // Write commits only on the edge where waitrequest is seen low
  assign wr_go = avs_write & ~s_r.wreq;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;

    // Line counter and comparators; stop beats begin when they coincide
    if (adv) begin
      s_nxt.line = line_nxt;
      if (line_nxt == vsbt_pkg::LINE_RESET) begin
        s_nxt.vblank = 1'b0;
        // Odd half-line count per field makes sync land alternately
        s_nxt.field = s_r.interlace ? ~s_r.field : 1'b0; // [R7]
      end
      if (line_nxt == blank_thr) begin
        s_nxt.vblank = 1'b1; // [R1] [R3]
      end
      if (line_nxt == line_plus(crt_begin, vsbt_pkg::CRT_OFFSET)) begin
        s_nxt.vsync = 1'b1; // [R5]
      end
      if (line_nxt == line_plus(crt_stop, vsbt_pkg::CRT_OFFSET)) begin
        s_nxt.vsync = 1'b0; // [R4]
      end
      if (line_nxt == line_plus(fp_begin, vsbt_pkg::PANEL_OFFSET)) begin
        s_nxt.fp_int = 1'b1; // [R9]
      end
      if (line_nxt == line_plus(fp_stop, vsbt_pkg::PANEL_OFFSET)) begin
        s_nxt.fp_int = 1'b0; // [R8]
      end
    end

    // One wait state per access, then release for one cycle
    s_nxt.wreq = 1'b1;
    if ((avs_read | avs_write) & s_r.wreq) begin
      s_nxt.wreq = 1'b0;
    end

    // Read data are loaded as waitrequest drops, so they stand at that edge
    if (avs_read & s_r.wreq) begin
      unique case (avs_address)
        vsbt_pkg::OFS_CRT_VSYNC: begin
          s_nxt.rdata = s_r.crt_reg; // [R11]
        end
        vsbt_pkg::OFS_PANEL_VSYNC: begin
          s_nxt.rdata = s_r.panel_reg; // [R12]
        end
        vsbt_pkg::OFS_CONTROL: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[vsbt_pkg::CTL_INTERLACE_BIT] = s_r.interlace;
          s_nxt.rdata[vsbt_pkg::CTL_LOCK_BIT] = s_r.lock;
        end
        vsbt_pkg::OFS_GEOMETRY: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[vsbt_pkg::STOP_LO +: vsbt_pkg::LINE_W] = s_r.total;
          s_nxt.rdata[vsbt_pkg::BEGIN_LO +: vsbt_pkg::LINE_W] = s_r.visible;
        end
        vsbt_pkg::OFS_BLANK: begin
          s_nxt.rdata = {21'h000000, s_r.blank_start};
        end
        vsbt_pkg::OFS_STATUS: begin
          s_nxt.rdata = {21'h000000, s_r.line};
          s_nxt.rdata[vsbt_pkg::STS_FIELD_BIT] = s_r.field;
          s_nxt.rdata[vsbt_pkg::STS_VBLANK_BIT] = s_r.vblank;
          s_nxt.rdata[vsbt_pkg::STS_VSYNC_BIT] = s_r.vsync;
        end
        default: begin
          s_nxt.rdata = '0; // Unmapped reads return zero
        end
      endcase
    end

    // Writes; the lock guards the sync, geometry and blank registers, not control
    if (wr_go) begin
      unique case (avs_address)
        vsbt_pkg::OFS_CRT_VSYNC: begin
          if (!s_r.lock) begin
            s_nxt.crt_reg = merge32(s_r.crt_reg, avs_writedata, avs_byteenable) &
                            vsbt_pkg::SYNC_REG_MASK; // [R11]
          end
        end
        vsbt_pkg::OFS_PANEL_VSYNC: begin
          if (!s_r.lock) begin
            s_nxt.panel_reg = merge32(s_r.panel_reg, avs_writedata, avs_byteenable) &
                              vsbt_pkg::SYNC_REG_MASK; // [R12]
          end
        end
        vsbt_pkg::OFS_CONTROL: begin
          if (avs_byteenable[0]) begin
            s_nxt.interlace = avs_writedata[vsbt_pkg::CTL_INTERLACE_BIT];
            s_nxt.lock = avs_writedata[vsbt_pkg::CTL_LOCK_BIT];
          end
        end
        vsbt_pkg::OFS_GEOMETRY: begin
          if (!s_r.lock) begin
            s_nxt.total = geo_wr[vsbt_pkg::STOP_LO +: vsbt_pkg::LINE_W];
            s_nxt.visible = geo_wr[vsbt_pkg::BEGIN_LO +: vsbt_pkg::LINE_W];
          end
        end
        vsbt_pkg::OFS_BLANK: begin
          if (!s_r.lock) begin
            s_nxt.blank_start = blank_wr[vsbt_pkg::BEGIN_LO +: vsbt_pkg::LINE_W];
          end
        end
        default: begin
          s_nxt.rdata = s_r.rdata; // Unmapped or read-only writes are dropped
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.crt_reg <= vsbt_pkg::SYNC_REG_RESET;
      s_r.panel_reg <= vsbt_pkg::SYNC_REG_RESET;
      s_r.wreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_waitrequest = s_r.wreq;
  assign avs_readdata = s_r.rdata;
  assign vblank = s_r.vblank;
  assign crt_vsync = s_r.vsync;

  ////////////////////////////////////////////////////////////////////////////
  // Panel output stage
  vsbt_panel_stage u_panel_stage (
    .core_clk(core_clk),
    .srst(srst),
    .fp_vsync_int(s_r.fp_int),
    .panel_vsync(panel_vsync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  blank_rise_a: assert property (@(posedge core_clk) disable iff (srst) // [R1]
    $rose(s_r.vblank) && !$past(s_r.interlace) |->
      s_r.line == 11'($past(s_r.blank_start) + 11'h001))
    else $error("blank rose at wrong line");

  ilace_blank_a: assert property (@(posedge core_clk) disable iff (srst) // [R3]
    $rose(s_r.vblank) && $past(s_r.interlace) |->
      s_r.line == 11'($past(s_r.visible) + 11'h002))
    else $error("interlaced blank rose at wrong line");

  sync_rise_a: assert property (@(posedge core_clk) disable iff (srst) // [R5]
    $rose(crt_vsync) |-> s_r.line == 11'($past(crt_begin) + 11'h001))
    else $error("crt sync rose at wrong line");

  sync_fall_a: assert property (@(posedge core_clk) disable iff (srst) // [R4]
    $fell(crt_vsync) |-> s_r.line == 11'($past(crt_stop) + 11'h001))
    else $error("crt sync fell at wrong line");

  panel_rise_a: assert property (@(posedge core_clk) disable iff (srst) // [R9]
    $rose(s_r.fp_int) |-> s_r.line == 11'($past(fp_begin) + 11'h002))
    else $error("panel sync rose at wrong line");

  panel_fall_a: assert property (@(posedge core_clk) disable iff (srst) // [R8]
    $fell(s_r.fp_int) |-> s_r.line == 11'($past(fp_stop) + 11'h002))
    else $error("panel sync fell at wrong line");

  panel_delay_a: assert property (@(posedge core_clk) disable iff (srst) // [R10]
    s_r.fp_int != panel_vsync |=> panel_vsync == $past(s_r.fp_int))
    else $error("panel sync not registered once");

  crt_lock_a: assert property (@(posedge core_clk) disable iff (srst) // [R11]
    wr_go && s_r.lock && avs_address == vsbt_pkg::OFS_CRT_VSYNC |=> $stable(s_r.crt_reg))
    else $error("locked crt register changed");

  panel_lock_a: assert property (@(posedge core_clk) disable iff (srst) // [R12]
    wr_go && s_r.lock && avs_address == vsbt_pkg::OFS_PANEL_VSYNC |=>
      $stable(s_r.panel_reg))
    else $error("locked panel register changed");

  line_wrap_a: assert property (@(posedge core_clk) disable iff (srst) // [R15]
    adv && s_r.line == s_r.total |=> s_r.line == 11'h000 ##1 !adv [*2] |-> s_r.line == 11'h000)
    else $error("line counter failed to wrap");

  half_line_a: assert property (@(posedge core_clk) disable iff (srst) // [R6]
    s_r.interlace && mid_line_pls && s_r.line != s_r.total |=>
      s_r.line == 11'($past(s_r.line) + 11'h001))
    else $error("mid-line did not advance counter");

  line_hold_a: assert property (@(posedge core_clk) disable iff (srst) // [R13]
    !adv |=> $stable(s_r.line))
    else $error("line counter moved without a line event");

  wait_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not pulse low once");

  // Counter, field, blank, panel, lock and handshake checks
  field_flip_a: assert property (@(posedge core_clk) disable iff (srst) // [R7]
    adv && s_r.interlace && s_r.line == s_r.total |=> s_r.field != $past(s_r.field))
    else $error("field bit did not toggle at wrap");

  prog_mid_a: assert property (@(posedge core_clk) disable iff (srst) // [R6]
    !s_r.interlace && mid_line_pls && !line_end_pls |=> $stable(s_r.line))
    else $error("mid-line moved counter while progressive");

  line_step_a: assert property (@(posedge core_clk) disable iff (srst) // [R15]
    adv && s_r.line != s_r.total |=> s_r.line == 11'($past(s_r.line) + 11'h001))
    else $error("line counter did not step by one");

  blank_clear_a: assert property (@(posedge core_clk) disable iff (srst) // [R15]
    $fell(vblank) |-> s_r.line == vsbt_pkg::LINE_RESET)
    else $error("blank cleared away from line zero");

  panel_lag_a: assert property (@(posedge core_clk) disable iff (srst) // [R10]
    $rose(s_r.fp_int) |=> panel_vsync)
    else $error("panel sync did not follow one clock later");

  lock_geom_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_go && s_r.lock && avs_address == vsbt_pkg::OFS_GEOMETRY |=>
      $stable(s_r.total) && $stable(s_r.visible))
    else $error("locked geometry changed");

  wait_rest_a: assert property (@(posedge core_clk) disable iff (srst)
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");

  rdata_hold_a: assert property (@(posedge core_clk) disable iff (srst) // [R11] [R12]
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a new read");

endmodule // vsbt_timing

// >>> bench/vsbt_line_src.sv
// Purpose: Horizontal timing stand-in that feeds scan line events to the block
// Assumes: Same clock as the block, events are one-cycle pulses
// Notes: Gap between events is chosen per call, so the source can be quick or slow
`timescale 1ns/1ps

module vsbt_line_src (
  input wire logic core_clk,
  output logic line_end_pls,
  output logic mid_line_pls
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle until the bench asks for an event
  initial begin
    line_end_pls = 1'b0;
    mid_line_pls = 1'b0;
  end

  // One event per call: a half-line or a full-line mark, never both at once
  task automatic send(input bit mid, input int gap);
    @(posedge core_clk);
    mid_line_pls <= mid;
    line_end_pls <= !mid;
    @(posedge core_clk);
    mid_line_pls <= 1'b0;
    line_end_pls <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask
endmodule // vsbt_line_src

// >>> bench/vsbt_timing_tb.sv
// Purpose: Self-checking bench for vertical blank, CRT sync and panel sync timing
// Assumes: Bus waits for waitrequest low, outputs settle two edges after an event
// Notes: Expected line count and thresholds are modelled here from the field values
`timescale 1ns/1ps

module vsbt_timing_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic line_end_pls;
  logic mid_line_pls;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h00000000;
  logic avs_waitrequest;
  logic [31:0] avs_readdata;
  logic vblank;
  logic crt_vsync;
  logic panel_vsync;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int rises;
  bit ilace;
  bit last_mid;
  bit prev_sync;
  logic exp_vb;
  logic exp_vs;
  logic fld;
  logic [10:0] line_exp, total, vis, bs, cb, cs, pb, ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard sized well above the planned run
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      stop_test();
    end
  end

  vsbt_timing dut (.core_clk(core_clk), .srst(srst), .line_end_pls(line_end_pls),
    .mid_line_pls(mid_line_pls), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .vblank(vblank),
    .crt_vsync(crt_vsync), .panel_vsync(panel_vsync));
  vsbt_line_src src (.core_clk(core_clk), .line_end_pls(line_end_pls),
    .mid_line_pls(mid_line_pls));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparisons and verdict
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_word(name, {31'h00000000, exp}, {31'h00000000, got});
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus access: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp,
                        input logic [31:0] msk);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check_word(name, exp & msk, q & msk);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    line_exp = 11'h000;
    prev_sync = 1'b0;
    rises = 0;
    fld = 1'b0;
    exp_vb = 1'b0;
    exp_vs = 1'b0;
  endtask

  // Program every threshold while the line counter rests at zero
  task automatic configure();
    wr(vsbt_pkg::OFS_CONTROL, {31'h00000000, ilace});
    wr(vsbt_pkg::OFS_GEOMETRY, {5'h00, total, 5'h00, vis});
    wr(vsbt_pkg::OFS_BLANK, {21'h000000, bs});
    wr(vsbt_pkg::OFS_CRT_VSYNC, {5'h00, cs, 5'h00, cb});
    wr(vsbt_pkg::OFS_PANEL_VSYNC, {5'h00, ps, 5'h00, pb});
  endtask

  // One line event, then the outputs against the modelled line count
  task automatic step(input bit mid, input int gap);
    logic [10:0] blank_on;
    src.send(mid, gap);
    if (!mid || ilace) begin
      if (line_exp == total) fld = ilace ? !fld : 1'b0;
      line_exp = (line_exp == total) ? 11'h000 : line_exp + 11'h001;
    end
    @(negedge core_clk);
    blank_on = ilace ? vis + 11'h002 : bs + 11'h001;
    exp_vb = line_exp != 0 && line_exp >= blank_on;
    exp_vs = line_exp >= cb + 11'h001 && line_exp < cs + 11'h001;
    check_bit("vblank", exp_vb, vblank);
    check_bit("crt_vsync", exp_vs, crt_vsync);
    check_bit("panel_vsync", line_exp >= pb + 11'h002 && line_exp < ps + 11'h002,
              panel_vsync);
    // Start kind is taken from the sync the design really raised
    if (ilace && crt_vsync === 1'b1 && !prev_sync) begin
      rises++;
      if (rises > 1) check_bit("sync_start_kind", !last_mid, mid);
      last_mid = mid;
    end
    prev_sync = (crt_vsync === 1'b1);
  endtask

  task automatic run(input int n);
    for (int i = 0; i < n; i++) step(i % 2 == 0, 2 + i % 3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    rd_chk("crt_reset", vsbt_pkg::OFS_CRT_VSYNC, 32'h00000000, 32'hffffffff);
    rd_chk("panel_reset", vsbt_pkg::OFS_PANEL_VSYNC, 32'h00000000, 32'hffffffff);
    rd_chk("unmapped", 16'h8310, 32'h00000000, 32'hffffffff);
    wr(vsbt_pkg::OFS_CRT_VSYNC, 32'hffffffff);
    rd_chk("crt_mask", vsbt_pkg::OFS_CRT_VSYNC, 32'h07ff07ff, 32'hffffffff);
    wr(vsbt_pkg::OFS_PANEL_VSYNC, 32'hffffffff);
    rd_chk("panel_mask", vsbt_pkg::OFS_PANEL_VSYNC, 32'h07ff07ff, 32'hffffffff);
    wr(vsbt_pkg::OFS_CONTROL, 32'h00000002);
    wr(vsbt_pkg::OFS_CRT_VSYNC, 32'h00050004);
    wr(vsbt_pkg::OFS_PANEL_VSYNC, 32'h00050004);
    rd_chk("crt_locked", vsbt_pkg::OFS_CRT_VSYNC, 32'h07ff07ff, 32'hffffffff);
    rd_chk("panel_locked", vsbt_pkg::OFS_PANEL_VSYNC, 32'h07ff07ff, 32'hffffffff);
    wr(vsbt_pkg::OFS_CONTROL, 32'h00000000);
    wr(vsbt_pkg::OFS_CRT_VSYNC, 32'h000e000c);
    rd_chk("crt_unlocked", vsbt_pkg::OFS_CRT_VSYNC, 32'h000e000c, 32'hffffffff);
    $display("test registers done");
    // Progressive: half-line marks must be ignored
    ilace = 1'b0;
    total = 11'd20;
    vis = 11'd9;
    bs = 11'd10;
    cb = 11'd12;
    cs = 11'd14;
    pb = 11'd12;
    ps = 11'd14;
    configure();
    run(90);
    rd_chk("status", vsbt_pkg::OFS_STATUS, {13'h0000, exp_vs, exp_vb, fld, 5'h00, line_exp},
           32'h0007ffff);
    $display("test progressive done");
    // Interlaced, odd half-line count per field so the sync start alternates
    do_reset();
    ilace = 1'b1;
    bs = vis + 11'h001;
    cb = 11'd4;
    cs = 11'd6;
    pb = 11'd5;
    ps = 11'd8;
    configure();
    run(150);
    rd_chk("status", vsbt_pkg::OFS_STATUS, {13'h0000, exp_vs, exp_vb, fld, 5'h00, line_exp},
           32'h0007ffff);
    $display("test interlaced done");
    stop_test();
  end
endmodule // vsbt_timing_tb
